// File: shared/ldio_pkg.sv
// What this block does
// - A device whose base lies outside its permitted range decodes nothing.
// - After reset floppy interrupt select holds 0x06; other devices hold none.
// - After reset DMA select is 0x02 for floppy, 0x04 for devices three and five.
// - Floppy base 0x0100..0x0FF8 on 8 bytes; offsets 0 to 5 and 7 decode.
// - Parallel base on 4 bytes up to 0x0FFC decodes only offsets 0 to 2.
// - Parallel offsets 3 to 7 decode only when its base is 8-byte aligned.
// - Keyboard decodes fixed at 0x60 data and 0x64 command/status, never relocated.
// - Game port base 0x0100..0x0FFF on 1 byte; one register at offset zero.
// - Config port base from global config_port_base_low/config_port_base_high, 0x0100..0x0FFE on 2 bytes.
// - Host writes index at config port, then accesses data at port plus one.
// - Device base is index device_base_high as bits 15:8 and device_base_low as bits 7:0.
// - Decode uses address bits 11:0; bits 15:12 must be zero when global bit set.
// - At power up config port is 0x02E or 0x04E chosen by the strap.
package ldio_pkg;
   localparam int unsigned NLDN = 12;
   localparam logic [3:0] LDN_FLP = 4'h0;
   localparam logic [3:0] LDN_PP = 4'h3;
   localparam logic [3:0] LDN_SP2 = 4'h5;
   localparam logic [3:0] LDN_KBD = 4'h7;
   localparam logic [3:0] LDN_GAME = 4'h9;
   // One bit per logical device number that is reserved.
   localparam logic [NLDN-1:0] LDN_RSVD = 12'h146;
   // Configuration register indices.
   localparam logic [7:0] IDX_LDN = 8'h07;
   localparam logic [7:0] IDX_GLOBAL = 8'h24;
   localparam logic [7:0] IDX_CFG_LO = 8'h26;
   localparam logic [7:0] IDX_CFG_HI = 8'h27;
   localparam logic [7:0] IDX_ACT = 8'h30;
   localparam logic [7:0] IDX_BASE_HI = 8'h60;
   localparam logic [7:0] IDX_BASE_LO = 8'h61;
   localparam logic [7:0] IDX_IRQ = 8'h70;
   localparam logic [7:0] IDX_DMA = 8'h74;
   localparam int unsigned GLB_FULL16_BIT = 6;
   // Base ranges and alignment masks.
   localparam logic [15:0] BASE_LO = 16'h0100;
   localparam logic [15:0] FLP_HI = 16'h0ff8;
   localparam logic [15:0] PP4_HI = 16'h0ffc;
   localparam logic [15:0] PP8_HI = 16'h0ff8;
   localparam logic [15:0] GAME_HI = 16'h0fff;
   localparam logic [15:0] CFG_HI = 16'h0ffe;
   localparam logic [15:0] FLP_AMASK = 16'h0007;
   localparam logic [15:0] PP4_AMASK = 16'h0003;
   localparam logic [15:0] PP8_AMASK = 16'h0007;
   localparam logic [15:0] GAME_AMASK = 16'h0000;
   localparam logic [15:0] CFG_AMASK = 16'h0001;
   localparam int unsigned PP_ALIGN8_BIT = 2;
   localparam logic [2:0] FLP_HOLE = 3'h6;
   localparam logic [2:0] PP_EPP_FIRST = 3'h3;
   localparam logic [15:0] KBD_DATA = 16'h0060;
   localparam logic [15:0] KBD_CMD = 16'h0064;
   localparam logic [3:0] HI_ZERO = 4'h0;
   localparam logic [15:0] CFG_BOOT0 = 16'h002e;
   localparam logic [15:0] CFG_BOOT1 = 16'h004e;
   localparam logic [3:0] IRQ_FLP_DEF = 4'h6;
   localparam logic [3:0] IRQ_DEF = 4'h0;
   localparam logic [2:0] DMA_FLP_DEF = 3'h2;
   localparam logic [2:0] DMA_NONE = 3'h4;
   localparam logic [1:0] BOOT_CYC = 2'h3;

   typedef enum logic [1:0] {PH_BOOT = 2'b01, PH_RUN = 2'b10} ldio_phase_t;

   // One host I/O cycle as presented by the bus front end.
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } ldio_io_t;

   // Which window claimed the last cycle.
   typedef struct packed {
      logic cfg;
      logic flp;
      logic pp;
      logic epp;
      logic kbd;
      logic game;
   } ldio_sel_t;

   typedef struct packed {
      ldio_phase_t phase;
      logic [1:0] boot_cnt;
      logic [7:0] index;
      logic [7:0] ldn;
      logic [7:0] glb;
      logic [7:0] cfg_lo;
      logic [7:0] cfg_hi;
      logic [15:0] cfg_base;
      logic [NLDN-1:0] act;
      logic [NLDN-1:0][15:0] base;
      logic [NLDN-1:0][3:0] irq;
      logic [NLDN-1:0][2:0] dma;
      logic claim;
      logic [7:0] rdata;
      ldio_sel_t sel;
      logic [2:0] off;
   } ldio_state_t;

   // True when the base, with bits below the alignment dropped, is in range.
   function automatic logic base_ok(input logic [15:0] b, input logic [15:0] lo,
                                    input logic [15:0] hi, input logic [15:0] amask);
      logic [15:0] al;
      al = b & ~amask;
      return (al >= lo) && (al <= hi);
   endfunction

   // Value of every control register after reset.
   function automatic ldio_state_t rst_state();
      ldio_state_t s;
      s = '0;
      s.phase = PH_BOOT;
      s.cfg_base = CFG_BOOT0;
      s.irq[LDN_FLP] = IRQ_FLP_DEF;
      s.dma[LDN_FLP] = DMA_FLP_DEF;
      s.dma[LDN_PP] = DMA_NONE;
      s.dma[LDN_SP2] = DMA_NONE;
      return s;
   endfunction
endpackage

// File: rtl/ldio_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser for an asynchronous level.
module ldio_sync (
   input wire logic clk, // Clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic d, // Asynchronous level.
   output logic q // Synchronised level.
);
   typedef struct packed {
      logic s1;
      logic s2;
   } ldio_sync_st_t;

   ldio_sync_st_t st_r;
   ldio_sync_st_t st_nxt;

   // Only the second stage is read outside.
   always_comb begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule // ldio_sync
`default_nettype wire

// File: rtl/ldio_win.sv
`timescale 1ns/10ps
`default_nettype none
// Relocatable window check: base validity, address match and offset.
module ldio_win #(
   parameter logic [15:0] LO = 16'h0100,
   parameter logic [15:0] HI = 16'h0ff8,
   parameter logic [15:0] AMASK = 16'h0007
) (
   input wire logic [15:0] base, // Programmed base.
   input wire logic [15:0] addr, // Host address.
   input wire logic full16, // Require upper nibble zero.
   output logic valid, // Base lies in the permitted range.
   output logic hit, // Address falls in the window.
   output logic [2:0] off // Offset inside the window.
);
   logic [15:0] base_al;

   // Low base bits are dropped so the window starts on its boundary.
   assign base_al = base & ~AMASK;
   assign valid = ldio_pkg::base_ok(base, LO, HI, AMASK);
   assign hit = valid && ((addr[11:0] & ~AMASK[11:0]) == base_al[11:0])
                && (!full16 || addr[15:12] == ldio_pkg::HI_ZERO);
   assign off = addr[2:0] & AMASK[2:0];
endmodule // ldio_win
`default_nettype wire

// File: rtl/ldio_decoder.sv
`timescale 1ns/10ps
`default_nettype none
// Configuration register bank and I/O window decoder for the logical devices.
module ldio_decoder (
   input wire logic clk, // 20 MHz host bus clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire ldio_pkg::ldio_io_t io_req, // Host I/O cycle, one per valid cycle.
   input wire logic config_port_strap, // Strap choosing the boot config port.
   output logic io_claim, // Cycle claimed, one cycle after the request.
   output logic [7:0] io_rdata, // Config read data, zero otherwise.
   output ldio_pkg::ldio_sel_t dev_sel, // Window that claimed the cycle.
   output logic [2:0] dev_off // Register offset inside that window.
);
   ldio_pkg::ldio_state_t st_r;
   ldio_pkg::ldio_state_t st_nxt;
   logic strap_s;
   logic full16;
   logic cfg_hit, flp_valid, flp_hit, pp4_hit, pp8_hit, game_hit;
   logic [2:0] cfg_off, flp_off, pp4_off, pp8_off, game_off;
   logic [3:0] lsel;

   // True for a logical device number that holds registers.
   function automatic logic ldn_ok(input logic [7:0] n);
      return (n < 8'(ldio_pkg::NLDN)) && !ldio_pkg::LDN_RSVD[n[3:0]];
   endfunction

   // True for a device that carries a DMA channel select.
   function automatic logic dma_ok(input logic [3:0] n);
      return (n == ldio_pkg::LDN_FLP) || (n == ldio_pkg::LDN_PP) || (n == ldio_pkg::LDN_SP2);
   endfunction

   // Fixed address compare, with optional upper-nibble qualification.
   function automatic logic fixed_eq(input logic [15:0] a, input logic [15:0] t,
                                     input logic f16);
      return (a[11:0] == t[11:0]) && (!f16 || a[15:12] == ldio_pkg::HI_ZERO);
   endfunction

   // Read mux of the indexed configuration registers.
   function automatic logic [7:0] reg_read(input ldio_pkg::ldio_state_t s);
      logic [3:0] n;
      logic [7:0] v;
      n = s.ldn[3:0];
      v = 8'h00;
      case (s.index)
         ldio_pkg::IDX_LDN: v = s.ldn;
         ldio_pkg::IDX_GLOBAL: v = s.glb;
         ldio_pkg::IDX_CFG_LO: v = s.cfg_lo;
         ldio_pkg::IDX_CFG_HI: v = s.cfg_hi;
         ldio_pkg::IDX_ACT: v = ldn_ok(s.ldn) ? {7'h00, s.act[n]} : 8'h00;
         ldio_pkg::IDX_BASE_HI: v = ldn_ok(s.ldn) ? s.base[n][15:8] : 8'h00;
         ldio_pkg::IDX_BASE_LO: v = ldn_ok(s.ldn) ? s.base[n][7:0] : 8'h00;
         ldio_pkg::IDX_IRQ: v = ldn_ok(s.ldn) ? {4'h0, s.irq[n]} : 8'h00;
         ldio_pkg::IDX_DMA: v = (ldn_ok(s.ldn) && dma_ok(n)) ? {5'h00, s.dma[n]} : 8'h00;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   ldio_sync u_strap (
      .clk(clk),
      .rst_n(rst_n),
      .d(config_port_strap),
      .q(strap_s)
   );

   assign full16 = st_r.glb[ldio_pkg::GLB_FULL16_BIT];
   assign lsel = st_r.ldn[3:0];

   // Configuration port window, index at even and data at odd address.
   ldio_win #(.LO(16'h0000), .HI(16'hfffe), .AMASK(ldio_pkg::CFG_AMASK)) u_cfg (
      .base(st_r.cfg_base),
      .addr(io_req.addr),
      .full16(full16),
      .valid(),
      .hit(cfg_hit),
      .off(cfg_off)
   );

   ldio_win #(.LO(ldio_pkg::BASE_LO), .HI(ldio_pkg::FLP_HI), .AMASK(ldio_pkg::FLP_AMASK)) u_flp (
      .base(st_r.base[ldio_pkg::LDN_FLP]),
      .addr(io_req.addr),
      .full16(full16),
      .valid(flp_valid),
      .hit(flp_hit),
      .off(flp_off)
   );

   ldio_win #(.LO(ldio_pkg::BASE_LO), .HI(ldio_pkg::PP4_HI), .AMASK(ldio_pkg::PP4_AMASK)) u_pp4 (
      .base(st_r.base[ldio_pkg::LDN_PP]),
      .addr(io_req.addr),
      .full16(full16),
      .valid(),
      .hit(pp4_hit),
      .off(pp4_off)
   );

   ldio_win #(.LO(ldio_pkg::BASE_LO), .HI(ldio_pkg::PP8_HI), .AMASK(ldio_pkg::PP8_AMASK)) u_pp8 (
      .base(st_r.base[ldio_pkg::LDN_PP]),
      .addr(io_req.addr),
      .full16(full16),
      .valid(),
      .hit(pp8_hit),
      .off(pp8_off)
   );

   ldio_win #(.LO(ldio_pkg::BASE_LO), .HI(ldio_pkg::GAME_HI), .AMASK(ldio_pkg::GAME_AMASK)) u_game (
      .base(st_r.base[ldio_pkg::LDN_GAME]),
      .addr(io_req.addr),
      .full16(full16),
      .valid(),
      .hit(game_hit),
      .off(game_off)
   );

   // Boot sequencing, indexed register access and device window decode.
   always_comb begin
      logic [15:0] cand;
      st_nxt = st_r;
      cand = 16'h0000;
      st_nxt.claim = 1'b0;
      st_nxt.rdata = 8'h00;
      st_nxt.sel = '0;
      st_nxt.off = 3'h0;
      case (st_r.phase)
         ldio_pkg::PH_BOOT: begin
            // Wait for the synchronised strap before choosing the port.
            st_nxt.boot_cnt = st_r.boot_cnt + 2'h1;
            if (st_r.boot_cnt == ldio_pkg::BOOT_CYC) begin
               st_nxt.cfg_base = strap_s ? ldio_pkg::CFG_BOOT1 : ldio_pkg::CFG_BOOT0;
               st_nxt.phase = ldio_pkg::PH_RUN;
            end
         end
         ldio_pkg::PH_RUN: begin
            if (io_req.valid && cfg_hit) begin
               st_nxt.claim = 1'b1;
               st_nxt.sel.cfg = 1'b1;
               st_nxt.off = cfg_off;
               if (cfg_off[0] == 1'b0) begin
                  // Index port.
                  if (io_req.write) begin
                     st_nxt.index = io_req.wdata;
                  end else begin
                     st_nxt.rdata = st_r.index;
                  end
               end else if (!io_req.write) begin
                  st_nxt.rdata = reg_read(st_r);
               end else begin
                  // Data port write to the indexed register.
                  case (st_r.index)
                     ldio_pkg::IDX_LDN: st_nxt.ldn = io_req.wdata;
                     ldio_pkg::IDX_GLOBAL: st_nxt.glb = io_req.wdata;
                     ldio_pkg::IDX_CFG_LO, ldio_pkg::IDX_CFG_HI: begin
                        if (st_r.index == ldio_pkg::IDX_CFG_LO) begin
                           st_nxt.cfg_lo = io_req.wdata;
                        end else begin
                           st_nxt.cfg_hi = io_req.wdata;
                        end
                        cand = {st_nxt.cfg_hi, st_nxt.cfg_lo};
                        // Only an in-range port base is taken, so the port never locks out.
                        if (ldio_pkg::base_ok(cand, ldio_pkg::BASE_LO, ldio_pkg::CFG_HI,
                                              ldio_pkg::CFG_AMASK)) begin
                           st_nxt.cfg_base = cand & ~ldio_pkg::CFG_AMASK;
                        end
                     end
                     ldio_pkg::IDX_ACT: begin
                        if (ldn_ok(st_r.ldn)) begin
                           st_nxt.act[lsel] = io_req.wdata[0];
                        end
                     end
                     ldio_pkg::IDX_BASE_HI: begin
                        if (ldn_ok(st_r.ldn) && lsel != ldio_pkg::LDN_KBD) begin
                           st_nxt.base[lsel][15:8] = io_req.wdata;
                        end
                     end
                     ldio_pkg::IDX_BASE_LO: begin
                        if (ldn_ok(st_r.ldn) && lsel != ldio_pkg::LDN_KBD) begin
                           st_nxt.base[lsel][7:0] = io_req.wdata;
                        end
                     end
                     ldio_pkg::IDX_IRQ: begin
                        if (ldn_ok(st_r.ldn)) begin
                           st_nxt.irq[lsel] = io_req.wdata[3:0];
                        end
                     end
                     ldio_pkg::IDX_DMA: begin
                        if (ldn_ok(st_r.ldn) && dma_ok(lsel)) begin
                           st_nxt.dma[lsel] = io_req.wdata[2:0];
                        end
                     end
                     default: ;
                  endcase
               end
            end else if (io_req.valid && st_r.act[ldio_pkg::LDN_KBD] &&
                         (fixed_eq(io_req.addr, ldio_pkg::KBD_DATA, full16) ||
                          fixed_eq(io_req.addr, ldio_pkg::KBD_CMD, full16))) begin
               st_nxt.claim = 1'b1;
               st_nxt.sel.kbd = 1'b1;
               st_nxt.off = io_req.addr[2:0];
            end else if (io_req.valid && st_r.act[ldio_pkg::LDN_FLP] && flp_hit &&
                         flp_off != ldio_pkg::FLP_HOLE) begin
               st_nxt.claim = 1'b1;
               st_nxt.sel.flp = 1'b1;
               st_nxt.off = flp_off;
            end else if (io_req.valid && st_r.act[ldio_pkg::LDN_PP] && pp4_hit &&
                         pp4_off < ldio_pkg::PP_EPP_FIRST) begin
               st_nxt.claim = 1'b1;
               st_nxt.sel.pp = 1'b1;
               st_nxt.off = pp4_off;
            end else if (io_req.valid && st_r.act[ldio_pkg::LDN_PP] && pp8_hit &&
                         !st_r.base[ldio_pkg::LDN_PP][ldio_pkg::PP_ALIGN8_BIT] &&
                         pp8_off >= ldio_pkg::PP_EPP_FIRST) begin
               st_nxt.claim = 1'b1;
               st_nxt.sel.epp = 1'b1;
               st_nxt.off = pp8_off;
            end else if (io_req.valid && st_r.act[ldio_pkg::LDN_GAME] && game_hit) begin
               st_nxt.claim = 1'b1;
               st_nxt.sel.game = 1'b1;
               st_nxt.off = game_off;
            end
         end
         default: st_nxt.phase = ldio_pkg::PH_BOOT;
      endcase
   end

   // State register; reset loads the documented defaults.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= ldio_pkg::rst_state();
      end else begin
         st_r <= st_nxt;
      end
   end

   assign io_claim = st_r.claim;
   assign io_rdata = st_r.rdata;
   assign dev_sel = st_r.sel;
   assign dev_off = st_r.off;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   irq_default_a: assert property ($rose(rst_n) |-> st_r.irq[0] == 4'h6 && st_r.irq[3] == 4'h0)
      else $error("Interrupt select reset value wrong.");
   dma_default_a: assert property ($rose(rst_n) |->
      st_r.dma[0] == 3'h2 && st_r.dma[3] == 3'h4 && st_r.dma[5] == 3'h4)
      else $error("DMA select reset value wrong.");
   flp_range_a: assert property (io_req.valid && !flp_valid |=> !st_r.sel.flp)
      else $error("Floppy decoded with invalid base.");
   flp_hole_a: assert property (st_r.sel.flp |-> st_r.off != 3'h6)
      else $error("Floppy offset six decoded.");
   pp_low_a: assert property (st_r.sel.pp |-> st_r.off < 3'h3)
      else $error("Parallel base offset above two.");
   epp_align_a: assert property (st_r.sel.epp |->
      !$past(st_r.base[3][2]) && st_r.off >= 3'h3)
      else $error("EPP decoded off 8-byte base.");
   kbd_fixed_a: assert property (io_req.valid && st_r.phase == ldio_pkg::PH_RUN && !cfg_hit &&
      st_r.act[7] && io_req.addr == 16'h0064 |=> io_claim && dev_sel.kbd)
      else $error("Keyboard command address not claimed.");
   game_base_a: assert property (st_r.sel.game |->
      $past(io_req.addr[11:0]) == $past(st_r.base[9][11:0]))
      else $error("Game port hit away from base.");
   cfg_range_a: assert property (st_r.phase == ldio_pkg::PH_RUN |->
      st_r.cfg_base == 16'h002e || st_r.cfg_base == 16'h004e ||
      (st_r.cfg_base >= 16'h0100 && st_r.cfg_base <= 16'h0ffe && !st_r.cfg_base[0]))
      else $error("Config port base out of range.");
   index_write_a: assert property (io_req.valid && io_req.write && cfg_hit && !cfg_off[0] &&
      st_r.phase == ldio_pkg::PH_RUN |=> st_r.index == $past(io_req.wdata) ##1 1'b1)
      else $error("Index write lost.");
   base_low_a: assert property (io_req.valid && io_req.write && cfg_hit && cfg_off[0] &&
      st_r.phase == ldio_pkg::PH_RUN && st_r.index == 8'h61 && st_r.ldn == 8'h00
      |=> st_r.base[0][7:0] == $past(io_req.wdata))
      else $error("Base low byte not stored.");
   full16_a: assert property (io_req.valid && full16 && io_req.addr[15:12] != 4'h0 |=> !io_claim)
      else $error("Upper address claimed in 16-bit mode.");
   boot_port_a: assert property ($rose(st_r.phase == ldio_pkg::PH_RUN) |->
      st_r.cfg_base == ($past(strap_s) ? 16'h004e : 16'h002e))
      else $error("Boot config port wrong.");
   rsvd_act_a: assert property (io_req.valid && io_req.write && cfg_hit && cfg_off[0] &&
      st_r.index == 8'h30 && !ldn_ok(st_r.ldn) |=> $stable(st_r.act))
      else $error("Reserved device register written.");
   flp_align_a: assert property (st_r.sel.flp |->
      $past(io_req.addr[11:3]) == $past(st_r.base[0][11:3]))
      else $error("Floppy window not on boundary.");

   kbd_hit_c: cover property (io_claim && dev_sel.kbd);
   epp_hit_c: cover property (io_claim && dev_sel.epp);
   cfg_read_c: cover property (io_claim && dev_sel.cfg && io_rdata != 8'h00);
   flp_hit_c: cover property (io_claim && dev_sel.flp ##1 io_claim && dev_sel.flp);
endmodule // ldio_decoder
`default_nettype wire

// File: sim/ldio_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host chipset model: issues one I/O cycle at a time and captures the answer.
module ldio_host (
   input wire logic clk, // Host bus clock.
   output var ldio_pkg::ldio_io_t io_req, // I/O cycle towards the decoder.
   input wire logic io_claim, // Claim answer.
   input wire logic [7:0] io_rdata, // Read data answer.
   input wire ldio_pkg::ldio_sel_t dev_sel, // Claiming window.
   input wire logic [2:0] dev_off // Offset inside the window.
);
   logic [9:0] hit; // Claim, window and offset seen in the answer cycle.
   logic [7:0] rdata; // Read data seen in the answer cycle.
   logic [15:0] port; // Current configuration port address.

   // The bus starts idle and the config port at its strap-low address.
   initial begin
      io_req = '0;
      port = 16'h002e;
   end

   // Drive after an edge, hold over the taking edge, capture, then release.
   task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      #2;
      io_req = '{valid: 1'b1, write: w, addr: a, wdata: d};
      @(posedge clk);
      #2;
      hit = {io_claim, dev_sel, dev_off};
      rdata = io_rdata;
      // Released lines show the inverse so a stale value cannot pass.
      io_req = '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
   endtask

   // Index written at the port, then data at the port plus one.
   task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] v);
      io(1'b1, port, idx);
      io(1'b1, port + 16'h0001, v);
   endtask

   // Index written at the port, then data read at the port plus one.
   task automatic cfg_rd(input logic [7:0] idx);
      io(1'b1, port, idx);
      io(1'b0, port + 16'h0001, 8'h00);
   endtask
endmodule // ldio_host
`default_nettype wire

// File: sim/test_logical_device_io_decoder.sv
`timescale 1ns/10ps
`default_nettype none
// Bench: programs each window through the config port and probes its decode.
module test_logical_device_io_decoder;
   localparam logic [9:0] NONE = 10'h000;
   localparam logic [5:0] S_CFG = 6'h20, S_FLP = 6'h10, S_PP = 6'h08;
   localparam logic [5:0] S_EPP = 6'h04, S_KBD = 6'h02, S_GAME = 6'h01;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic strap = 1'b0;
   ldio_pkg::ldio_io_t io_req;
   logic io_claim;
   logic [7:0] io_rdata;
   ldio_pkg::ldio_sel_t dev_sel;
   logic [2:0] dev_off;
   int fail_count = 0;
   int num_checks = 0;

   // Clock of 50 ns period.
   always #25 clk = ~clk;

   ldio_decoder dut (.clk(clk), .rst_n(rst_n), .io_req(io_req), .config_port_strap(strap),
      .io_claim(io_claim), .io_rdata(io_rdata), .dev_sel(dev_sel), .dev_off(dev_off));
   ldio_host host (.clk(clk), .io_req(io_req), .io_claim(io_claim), .io_rdata(io_rdata),
      .dev_sel(dev_sel), .dev_off(dev_off));

   // Compares claim, window and offset.
   task automatic chk_hit(input logic [9:0] got, input logic [9:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Compares register read data.
   task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Helpers: probe one address, write or read one config register.
   task automatic probe(input logic [15:0] a, input logic [9:0] e);
      host.io(1'b0, a, 8'h00);
      chk_hit(host.hit, e);
      chk_data(host.rdata, 8'h00);
   endtask
   task automatic cw(input logic [7:0] i, input logic [7:0] v);
      host.cfg_wr(i, v);
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] e);
      host.cfg_rd(i);
      chk_hit(host.hit, {1'b1, S_CFG, 3'h1});
      chk_data(host.rdata, e);
   endtask

   // Holds reset for 3 cycles, then waits out the boot phase.
   task automatic do_reset();
      @(posedge clk);
      #2;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #2;
      rst_n = 1'b1;
      repeat (5) @(posedge clk);
   endtask

   task automatic t_reset();
      rd(8'h70, 8'h06);
      rd(8'h74, 8'h02);
      cw(8'h07, 8'h03);
      rd(8'h74, 8'h04);
      rd(8'h70, 8'h00);
      cw(8'h07, 8'h05);
      rd(8'h74, 8'h04);
      cw(8'h70, 8'h0b);
      rd(8'h70, 8'h0b);
      cw(8'h07, 8'h01);
      cw(8'h70, 8'h05);
      rd(8'h70, 8'h00);
      cw(8'h30, 8'h01);
      rd(8'h30, 8'h00);
      host.io(1'b0, host.port, 8'h00);
      chk_hit(host.hit, {1'b1, S_CFG, 3'h0});
      chk_data(host.rdata, 8'h30);
      probe(16'h004e, NONE);
   endtask

   task automatic t_flp();
      cw(8'h07, 8'h00);
      cw(8'h60, 8'h03);
      cw(8'h61, 8'hf5);
      probe(16'h03f2, NONE);
      cw(8'h30, 8'h01);
      for (int i = 0; i < 8; i++) begin
         probe(16'h03f0 + 16'(i), (i == 6) ? NONE : {1'b1, S_FLP, 3'(i)});
      end
      probe(16'h13f2, {1'b1, S_FLP, 3'h2});
      cw(8'h24, 8'h40);
      probe(16'h13f2, NONE);
      probe(16'h03f2, {1'b1, S_FLP, 3'h2});
      cw(8'h24, 8'h00);
      cw(8'h60, 8'h0f);
      cw(8'h61, 8'hf8);
      probe(16'h0fff, {1'b1, S_FLP, 3'h7});
      cw(8'h60, 8'h00);
      probe(16'h00f8, NONE);
   endtask

   task automatic t_pp();
      cw(8'h07, 8'h03);
      cw(8'h60, 8'h03);
      cw(8'h61, 8'h78);
      cw(8'h30, 8'h01);
      for (int i = 0; i < 8; i++) begin
         probe(16'h0378 + 16'(i), {1'b1, (i < 3) ? S_PP : S_EPP, 3'(i)});
      end
      cw(8'h61, 8'h7c);
      for (int i = 0; i < 5; i++) begin
         probe(16'h037c + 16'(i), (i < 3) ? {1'b1, S_PP, 3'(i)} : NONE);
      end
      cw(8'h60, 8'h0f);
      cw(8'h61, 8'hfc);
      probe(16'h0ffe, {1'b1, S_PP, 3'h2});
   endtask

   task automatic t_kbd_game();
      cw(8'h07, 8'h07);
      cw(8'h60, 8'h03);
      cw(8'h30, 8'h01);
      rd(8'h60, 8'h00);
      probe(16'h0060, {1'b1, S_KBD, 3'h0});
      probe(16'h0064, {1'b1, S_KBD, 3'h4});
      probe(16'h0061, NONE);
      cw(8'h07, 8'h09);
      cw(8'h60, 8'h02);
      cw(8'h61, 8'h01);
      cw(8'h30, 8'h01);
      probe(16'h0201, {1'b1, S_GAME, 3'h0});
      probe(16'h0202, NONE);
      cw(8'h60, 8'h0f);
      cw(8'h61, 8'hff);
      rd(8'h61, 8'hff);
      probe(16'h0fff, {1'b1, S_GAME, 3'h0});
   endtask

   task automatic t_cfg();
      cw(8'h26, 8'h70);
      cw(8'h27, 8'h03);
      host.port = 16'h0370;
      rd(8'h26, 8'h70);
      probe(16'h002e, NONE);
      cw(8'h27, 8'h10);
      rd(8'h07, 8'h09);
      strap = 1'b1;
      do_reset();
      host.port = 16'h004e;
      rd(8'h70, 8'h06);
      probe(16'h002e, NONE);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      do_reset();
      t_reset();
      t_flp();
      t_pp();
      t_kbd_game();
      t_cfg();
      end_of_test();
   end

   // Watchdog well beyond the expected few hundred cycles.
   initial begin
      repeat (4000) @(posedge clk);
      fail_count++;
      end_of_test();
   end
endmodule // test_logical_device_io_decoder
`default_nettype wire
